// >>> rtl/rotate_sub_swap_xor_alu.sv
// datapath slice: rotate, subtract, nibble exchange, direction load, xor
// assumes one instruction per enabled cycle, inputs synchronous to core_clk
//
// Contract
// RULE1 - rotate left moves file bits up, top bit leaves through rollover only
// RULE2 - rotate right moves file bits down, low bit leaves through rollover only
// RULE3 - destination bit 0 writes accumulator, 1 writes the addressed file register
// RULE4 - subtract computes file minus accumulator, updates rollover, nibble rollover, null
// RULE5 - nibble exchange swaps bits 3:0 and 7:4, no flag changes
// RULE6 - direction load copies accumulator to direction register 6 or 7, no flags
// RULE7 - literal xor combines accumulator with an eight-bit literal, 0 to 255
// RULE8 - file xor combines accumulator with file register, only null flag updates
// RULE9 - subtract result goes by destination bit, file address covers 0 to 31
// RULE10 - rotate puts old rollover into vacated bit, outgoing bit becomes rollover
// RULE11 - literal xor writes accumulator; null flag set when xor result is zero
`timescale 1ns/1ps
`include "alu_defs.svh"

module rotate_sub_swap_xor_alu
    import alu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire instr_t instr,
    output logic [`ALU_DATA_W-1:0] accum_q,
    output flags_t flags_q,
    output logic [`ALU_DATA_W-1:0] dir_a_q,
    output logic [`ALU_DATA_W-1:0] dir_b_q,
    output logic [`ALU_DATA_W-1:0] result_q,
    output logic done_q
);

    // true for operations that carry a destination bit
    function automatic logic has_dest(input alu_op_t op);
        case (op)
            rotate_left_through_rollover,
            rotate_right_through_rollover,
            subtract_accum_from_file,
            nibble_exchange,
            file_exclusive_or: has_dest = 1'b1;
            default: has_dest = 1'b0;
        endcase
    endfunction

    // file register bank, 32 words, one write port
    logic [`ALU_DATA_W-1:0] file_q [`ALU_FILE_DEPTH];

    wire go = ce & instr.valid;
    wire [`ALU_DATA_W-1:0] file_rd = file_q[instr.addr]; // [RULE9]
    wire [`ALU_DATA_W-1:0] w_val = accum_q;

    // rotates pass the old rollover into the freed bit [RULE10]
    wire [`ALU_DATA_W-1:0] rot_l = {file_rd[`ALU_DATA_W-2:0], flags_q.rollover}; // [RULE1]
    wire [`ALU_DATA_W-1:0] rot_r = {flags_q.rollover, file_rd[`ALU_DATA_W-1:1]}; // [RULE2]

    // subtract via 9-bit difference; rollover set means no borrow
    wire [`ALU_DATA_W:0] diff = {1'b0, file_rd} - {1'b0, w_val}; // [RULE4]
    wire [`ALU_NIB_W:0] nib_diff = {1'b0, file_rd[`ALU_NIB_W-1:0]}
        - {1'b0, w_val[`ALU_NIB_W-1:0]};

    wire [`ALU_DATA_W-1:0] swap_v = {file_rd[`ALU_NIB_W-1:0],
        file_rd[`ALU_DATA_W-1:`ALU_NIB_W]}; // [RULE5]
    wire [`ALU_DATA_W-1:0] xorl_v = w_val ^ instr.lit; // [RULE7]
    wire [`ALU_DATA_W-1:0] xorf_v = w_val ^ file_rd; // [RULE8]

    // result selection per operation
    logic [`ALU_DATA_W-1:0] res_d;
    always_comb begin
        case (instr.op)
            rotate_left_through_rollover: res_d = rot_l;
            rotate_right_through_rollover: res_d = rot_r;
            subtract_accum_from_file: res_d = diff[`ALU_DATA_W-1:0];
            nibble_exchange: res_d = swap_v;
            direction_load: res_d = w_val;
            literal_exclusive_or: res_d = xorl_v;
            file_exclusive_or: res_d = xorf_v;
            op_load_literal: res_d = instr.lit;
            op_store_accum: res_d = w_val;
            default: res_d = `ALU_DATA_W'h00;
        endcase
    end

    // destination steering
    wire dest_ok = has_dest(instr.op);
    wire to_file = go & dest_ok & (instr.dest == `ALU_DEST_FILE); // [RULE3]
    wire store_file = go & (instr.op == op_store_accum);
    wire file_we = to_file | store_file;
    wire to_accum = go & ((dest_ok & (instr.dest == `ALU_DEST_ACCUM)) // [RULE3] [RULE9]
        | (instr.op == literal_exclusive_or) // [RULE11]
        | (instr.op == op_load_literal));

    // direction loads only for selector 6 or 7; other selectors are ignored
    wire dir_a_we = go & (instr.op == direction_load) & (instr.addr == `ALU_DIR_SEL_A);
    wire dir_b_we = go & (instr.op == direction_load) & (instr.addr == `ALU_DIR_SEL_B);

    // flag next values; only the flags each operation names may move
    wire is_sub = (instr.op == subtract_accum_from_file);
    wire is_xor = (instr.op == literal_exclusive_or) | (instr.op == file_exclusive_or);
    flags_t flags_d;
    always_comb begin
        flags_d = flags_q;
        if (instr.op == rotate_left_through_rollover) begin
            flags_d.rollover = file_rd[`ALU_DATA_W-1]; // [RULE1] [RULE10]
        end else if (instr.op == rotate_right_through_rollover) begin
            flags_d.rollover = file_rd[0]; // [RULE2] [RULE10]
        end else if (is_sub) begin
            flags_d.rollover = ~diff[`ALU_DATA_W]; // [RULE4]
            flags_d.nibble_rollover_flag = ~nib_diff[`ALU_NIB_W];
            flags_d.result_null = (diff[`ALU_DATA_W-1:0] == `ALU_DATA_W'h00);
        end else if (is_xor) begin
            flags_d.result_null = (res_d == `ALU_DATA_W'h00); // [RULE8] [RULE11]
        end
    end

    // file bank write; the generate keeps each word's reset and enable local
    for (genvar g = 0; g < `ALU_FILE_DEPTH; g++) begin : g_file
        always_ff @(posedge core_clk) begin
            if (rst) begin
                file_q[g] <= `ALU_FILE_RST;
            end else if (file_we && instr.addr == `ALU_ADDR_W'(g)) begin
                file_q[g] <= res_d; // [RULE3] [RULE9]
            end
        end
    end

    // accumulator and flags
    always_ff @(posedge core_clk) begin
        if (rst) begin
            accum_q <= `ALU_ACCUM_RST;
            flags_q <= '{`ALU_FLAG_RST, `ALU_FLAG_RST, `ALU_FLAG_RST};
        end else if (go) begin
            if (to_accum) begin
                accum_q <= res_d; // [RULE3] [RULE7] [RULE11]
            end
            flags_q <= flags_d;
        end
    end

    // direction registers reset to all-ones so pins start as inputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dir_a_q <= `ALU_DIR_RST;
            dir_b_q <= `ALU_DIR_RST;
        end else begin
            if (dir_a_we) begin
                dir_a_q <= w_val; // [RULE6]
            end
            if (dir_b_we) begin
                dir_b_q <= w_val; // [RULE6]
            end
        end
    end

    // last result and completion pulse for observation
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_q <= `ALU_DATA_W'h00;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= instr.valid;
            if (instr.valid) begin
                result_q <= res_d;
            end
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_issue(alu_op_t o);
        go && instr.op == o;
    endsequence

    sequence s_retire;
        done_q;
    endsequence

    property p_rot_left;
        s_issue(rotate_left_through_rollover) |=> s_retire
            and (result_q == {$past(file_rd[6:0]), $past(flags_q.rollover)}
            && flags_q.rollover == $past(file_rd[7])
            && flags_q.result_null == $past(flags_q.result_null));
    endproperty
    a_rot_left: assert property (p_rot_left) else $error("rotate left wrong"); // [RULE1]

    property p_rot_right;
        s_issue(rotate_right_through_rollover) |=> s_retire
            and (result_q == {$past(flags_q.rollover), $past(file_rd[7:1])}
            && flags_q.rollover == $past(file_rd[0])
            && flags_q.nibble_rollover_flag == $past(flags_q.nibble_rollover_flag));
    endproperty
    a_rot_right: assert property (p_rot_right) else $error("rotate right wrong"); // [RULE2]

    property p_dest;
        go && has_dest(instr.op) |=>
            (($past(instr.dest) == `ALU_DEST_ACCUM) ? (accum_q == result_q)
            : (accum_q == $past(accum_q) && file_q[$past(instr.addr)] == result_q));
    endproperty
    a_dest: assert property (p_dest) else $error("destination steering wrong"); // [RULE3]

    property p_sub;
        s_issue(subtract_accum_from_file) |=>
            result_q == $past(file_rd) - $past(accum_q)
            && flags_q.rollover == ($past(file_rd) >= $past(accum_q))
            && flags_q.nibble_rollover_flag == ($past(file_rd[3:0]) >= $past(accum_q[3:0]))
            && flags_q.result_null == (result_q == 8'h00);
    endproperty
    a_sub: assert property (p_sub) else $error("subtract wrong"); // [RULE4]

    property p_swap;
        s_issue(nibble_exchange) |=> result_q == {$past(file_rd[3:0]), $past(file_rd[7:4])}
            && $stable(flags_q);
    endproperty
    a_swap: assert property (p_swap) else $error("nibble exchange wrong"); // [RULE5]

    property p_dir;
        s_issue(direction_load) and (instr.addr == `ALU_DIR_SEL_B) |=>
            dir_b_q == $past(accum_q) && $stable(flags_q) && $stable(dir_a_q);
    endproperty
    a_dir: assert property (p_dir) else $error("direction load wrong"); // [RULE6]

    property p_xorl;
        s_issue(literal_exclusive_or) |=> accum_q == ($past(accum_q) ^ $past(instr.lit))
            && flags_q.result_null == (accum_q == 8'h00);
    endproperty
    a_xorl: assert property (p_xorl) else $error("literal xor wrong"); // [RULE7]

    property p_xorf;
        s_issue(file_exclusive_or) |=> result_q == ($past(accum_q) ^ $past(file_rd))
            && flags_q.rollover == $past(flags_q.rollover)
            && flags_q.nibble_rollover_flag == $past(flags_q.nibble_rollover_flag);
    endproperty
    a_xorf: assert property (p_xorf) else $error("file xor wrong"); // [RULE8]

    property p_sub_dest;
        s_issue(subtract_accum_from_file) and (instr.dest == `ALU_DEST_FILE) |=>
            file_q[$past(instr.addr)] == result_q && accum_q == $past(accum_q);
    endproperty
    a_sub_dest: assert property (p_sub_dest) else $error("subtract store wrong"); // [RULE9]

    property p_null;
        go && instr.op inside {literal_exclusive_or, file_exclusive_or} |=>
            flags_q.result_null == (result_q == 8'h00);
    endproperty
    a_null: assert property (p_null) else $error("null flag wrong"); // [RULE11]

    property p_idle;
        !ce |=> $stable(accum_q) && $stable(flags_q) && $stable(done_q);
    endproperty
    a_idle: assert property (p_idle) else $error("state moved while disabled"); // ce low freezes accumulator, flags and done

endmodule

// >>> inc/alu_defs.svh
// constants for the rotate/subtract/swap/xor datapath slice
// assumes inclusion by bare name from the package and the datapath
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

`define ALU_DATA_W 8
`define ALU_ADDR_W 5
`define ALU_FILE_DEPTH 32
`define ALU_NIB_W 4
`define ALU_DEST_ACCUM 1'b0
`define ALU_DEST_FILE 1'b1
`define ALU_DIR_SEL_A 5'h06
`define ALU_DIR_SEL_B 5'h07
`define ALU_ACCUM_RST 8'h00
`define ALU_FILE_RST 8'h00
`define ALU_DIR_RST 8'hFF
`define ALU_FLAG_RST 1'b0

`endif

// >>> inc/alu_pkg.sv
// types shared by the datapath slice and its bench
// assumes alu_defs.svh is on the include path
`include "alu_defs.svh"

package alu_pkg;

    // operation selector; load_literal and store_accum only fill registers
    typedef enum logic [3:0] {
        op_nop,
        rotate_left_through_rollover,
        rotate_right_through_rollover,
        subtract_accum_from_file,
        nibble_exchange,
        direction_load,
        literal_exclusive_or,
        file_exclusive_or,
        op_load_literal,
        op_store_accum
    } alu_op_t;

    // one instruction as it arrives in a cycle
    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [`ALU_ADDR_W-1:0] addr;
        logic dest;
        logic [`ALU_DATA_W-1:0] lit;
    } instr_t;

    // status flags kept by the slice
    typedef struct packed {
        logic rollover;
        logic nibble_rollover_flag;
        logic result_null;
    } flags_t;

endpackage

// >>> verif/rotate_sub_swap_xor_alu_test.sv
// self-checking bench for the rotate/subtract/swap/xor datapath slice
// assumes alu_pkg and alu_defs.svh compiled first; the design holds its own assertions
`timescale 1ns/1ps
`include "alu_defs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module rotate_sub_swap_xor_alu_test
    import alu_pkg::*;
;
    typedef struct packed {
        logic [7:0] res;
        logic chk_res;
        logic [7:0] acc;
        flags_t fl;
        logic [7:0] da;
        logic [7:0] db;
    } note_t;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    instr_t instr = '0;
    logic [7:0] accum_q, dir_a_q, dir_b_q, result_q;
    flags_t flags_q;
    logic done_q, took;
    logic exp_done = 1'b0;
    int err_count = 0;
    int checks = 0;
    note_t exp_q[$];
    logic [7:0] m_file [32];
    logic [7:0] m_acc = 8'h00;
    logic [7:0] m_da = 8'hFF;
    logic [7:0] m_db = 8'hFF;
    flags_t m_fl = '0;

    rotate_sub_swap_xor_alu dut (.core_clk(core_clk), .rst(rst), .ce(ce), .instr(instr),
        .accum_q(accum_q), .flags_q(flags_q), .dir_a_q(dir_a_q), .dir_b_q(dir_b_q),
        .result_q(result_q), .done_q(done_q));

    // 25 ns period
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // reference model notes the outcome, then presents the instruction after the edge
    task automatic exec(input alu_op_t op, input logic [4:0] a, input logic d,
                        input logic [7:0] k);
        logic [7:0] f;
        logic [7:0] r;
        logic wd;
        note_t n;
        f = m_file[a];
        r = 8'h00;
        wd = 1'b0;
        n.chk_res = 1'b1;
        case (op)
            rotate_left_through_rollover: begin
                r = {f[6:0], m_fl.rollover};
                m_fl.rollover = f[7];
                wd = 1'b1;
            end
            rotate_right_through_rollover: begin
                r = {m_fl.rollover, f[7:1]};
                m_fl.rollover = f[0];
                wd = 1'b1;
            end
            subtract_accum_from_file: begin
                r = f - m_acc;
                m_fl = '{f >= m_acc, f[3:0] >= m_acc[3:0], r == 8'h00};
                wd = 1'b1;
            end
            nibble_exchange: begin
                r = {f[3:0], f[7:4]};
                wd = 1'b1;
            end
            direction_load: begin
                r = m_acc;
                if (a == `ALU_DIR_SEL_A) m_da = m_acc;
                if (a == `ALU_DIR_SEL_B) m_db = m_acc;
            end
            literal_exclusive_or: begin
                r = m_acc ^ k;
                m_acc = r;
                m_fl.result_null = (r == 8'h00);
            end
            file_exclusive_or: begin
                r = m_acc ^ f;
                m_fl.result_null = (r == 8'h00);
                wd = 1'b1;
            end
            op_load_literal: begin
                m_acc = k;
                n.chk_res = 1'b0;
            end
            default: begin
                m_file[a] = m_acc;
                n.chk_res = 1'b0;
            end
        endcase
        if (wd && d) m_file[a] = r;
        if (wd && !d) m_acc = r;
        n.res = r;
        n.acc = m_acc;
        n.fl = m_fl;
        n.da = m_da;
        n.db = m_db;
        exp_q.push_back(n);
        @(posedge core_clk);
        #2;
        ce = 1'b1;
        instr = '{1'b1, op, a, d, k};
    endtask

    // one edge with no instruction taken; ce low must freeze everything
    task automatic idle(input logic en);
        @(posedge core_clk);
        #2;
        ce = en;
        // with ce low a valid instruction must still be ignored
        instr = '{!en, alu_op_t'(4'h1 + 4'($urandom_range(8))), 5'($urandom), 1'b1, 8'hA5};
    endtask

    // one note is consumed per taken edge that raised done
    initial begin
        forever begin
            @(posedge core_clk);
            took = (ce === 1'b1) && (rst === 1'b0) && (instr.valid === 1'b1);
            // done holds its last value while ce is low
            if (rst === 1'b1) exp_done = 1'b0;
            else if (ce === 1'b1) exp_done = (instr.valid === 1'b1);
            @(negedge core_clk);
            `CHK("done", exp_done, done_q)
            if (took && exp_q.size() > 0) begin
                note_t n;
                n = exp_q.pop_front();
                `CHK("accum", n.acc, accum_q)
                `CHK("flags", n.fl, flags_q)
                `CHK("dir_a", n.da, dir_a_q)
                `CHK("dir_b", n.db, dir_b_q)
                if (n.chk_res) `CHK("result", n.res, result_q)
            end
        end
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard, well beyond the planned run
    initial begin
        #(25 * 20000);
        err_count++;
        summarize();
    end

    initial begin
        void'($urandom(32'hE2428EBB));
        foreach (m_file[i]) m_file[i] = 8'h00;
        repeat (6) @(posedge core_clk);
        #2;
        rst = 1'b0;
        `CHK("rst_accum", 8'h00, accum_q)
        `CHK("rst_dirs", 16'hFFFF, {dir_a_q, dir_b_q})
        `CHK("rst_flags", 3'b000, flags_q)
        $display("test reset done");
        // boundary addresses, both carries, borrows and zero results
        exec(op_load_literal, 0, 0, 8'hA5);
        exec(op_store_accum, 31, 0, 0);
        exec(rotate_left_through_rollover, 31, 1, 0);
        exec(rotate_left_through_rollover, 31, 1, 0);
        exec(rotate_right_through_rollover, 31, 0, 0);
        exec(rotate_right_through_rollover, 31, 1, 0);
        exec(op_load_literal, 0, 0, 8'h10);
        exec(op_store_accum, 0, 0, 0);
        exec(op_load_literal, 0, 0, 8'h01);
        exec(subtract_accum_from_file, 0, 0, 0);
        exec(subtract_accum_from_file, 0, 1, 0);
        exec(subtract_accum_from_file, 0, 1, 0);
        exec(subtract_accum_from_file, 31, 0, 0);
        for (int i = 5; i < 9; i++) exec(direction_load, 5'(i), 0, 0);
        exec(nibble_exchange, 31, 1, 0);
        exec(literal_exclusive_or, 0, 0, 8'h00);
        exec(literal_exclusive_or, 0, 0, m_acc);
        exec(literal_exclusive_or, 0, 0, 8'hFF);
        exec(file_exclusive_or, 31, 0, 0);
        exec(file_exclusive_or, 31, 1, 0);
        idle(1'b1);
        $display("test directed done");
        // random ops back to back, with stalls and idle gaps
        for (int i = 0; i < 600; i++) begin
            if ($urandom_range(9) == 0) idle(1'($urandom));
            exec(alu_op_t'(4'h1 + 4'($urandom_range(8))), 5'($urandom), 1'($urandom),
                 8'($urandom));
        end
        idle(1'b1);
        repeat (3) @(posedge core_clk);
        `CHK("drained", 0, exp_q.size())
        $display("test random done");
        summarize();
    end
endmodule
